// ### hw/ppcd_pkg.sv
// Package for the per-port cable diagnostic and link control register bank
package ppcd_pkg;

  // Register byte offsets (all are word aligned)
  localparam logic [7:0] PPCD_OFS_CABLE_TEST = 8'h1c; // Cable test control and status
  localparam logic [7:0] PPCD_OFS_FAULT_LOW = 8'h20; // Fault count low byte
  localparam logic [7:0] PPCD_OFS_PORT1_SPEED = 8'h2c; // Port 1 link speed control
  localparam logic [7:0] PPCD_OFS_PORT2_SPEED = 8'h3c; // Port 2 link speed control
  localparam logic [7:0] PPCD_OFS_PORT_CTRL = 8'h40; // Force link, energy, loopback
  localparam logic [7:0] PPCD_OFS_IRQ_STATUS = 8'h44; // Sticky event status
  localparam logic [7:0] PPCD_OFS_IRQ_MASK = 8'h48; // Event mask

  // Cable test control and status field positions
  localparam int PPCD_CT_OUTCOME_HI = 6;
  localparam int PPCD_CT_OUTCOME_LO = 5;
  localparam int PPCD_CT_GO_BIT = 4;
  localparam int PPCD_CT_FAULT_HI_BIT = 0;

  // Port control field positions
  localparam int PPCD_PC_FORCE_LINK_BIT = 2;
  localparam int PPCD_PC_ENERGY_BIT = 1;
  localparam int PPCD_PC_LOOPBACK_BIT = 0;

  // Link speed control field positions
  localparam int PPCD_LS_AN_OFF_BIT = 7;
  localparam int PPCD_LS_SPEED_BIT = 6;
  localparam int PPCD_LS_DUPLEX_BIT = 5;
  localparam int PPCD_LS_RSVD_HI = 4;

  // Reset values
  localparam logic [7:0] PPCD_LS_RESET = 8'h5f; // Speed 100, reserved low bits set
  localparam logic [7:0] PPCD_ZERO8 = 8'h00;
  localparam logic [8:0] PPCD_ZERO9 = 9'h000;

  // Interrupt event bit positions
  localparam int PPCD_EV_TEST_DONE = 0;
  localparam int PPCD_EV_LINK_CHANGE = 1;
  localparam int PPCD_EV_TEST_FAULT = 2;

  // Cable test outcome codes
  typedef enum logic [1:0] {
    PPCD_CABLE_NORMAL = 2'h0,
    PPCD_CABLE_OPEN = 2'h1,
    PPCD_CABLE_SHORT = 2'h2,
    PPCD_CABLE_TEST_FAILED = 2'h3
  } ppcd_outcome_t;

  // Result handed back by the analog cable tester
  typedef struct packed {
    logic done;
    ppcd_outcome_t outcome;
    logic [8:0] fault_count;
  } ppcd_test_result_t;

  // Resolved operating mode for one port
  typedef struct packed {
    logic autoneg_on;
    logic speed_100;
    logic full_duplex;
  } ppcd_port_mode_t;

endpackage

// ### hw/ppcd_port_mode.sv
// Resolves one port's speed and duplex from its link speed control register
`timescale 1ns/1ps
`default_nettype none

module ppcd_port_mode
  import ppcd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Configuration
  input wire logic [7:0] ctrl_reg_value,
  input wire logic reduced_mii_mode,
  // Auto-negotiation result from the transceiver
  input wire logic autoneg_done,
  input wire logic autoneg_failed,
  input wire logic autoneg_speed_100,
  input wire logic autoneg_full_duplex,
  // Resolved mode
  output ppcd_port_mode_t mode
);

  logic an_off;
  ppcd_port_mode_t mode_next;

  // Disable bit is ignored in reduced MII switch mode
  assign an_off = ctrl_reg_value[PPCD_LS_AN_OFF_BIT] & ~reduced_mii_mode;

  // Choose forced or negotiated settings
  always_comb
  begin
    mode_next.autoneg_on = ~an_off;
    if (an_off | reduced_mii_mode)
    begin
      mode_next.speed_100 = ctrl_reg_value[PPCD_LS_SPEED_BIT];
      mode_next.full_duplex = ctrl_reg_value[PPCD_LS_DUPLEX_BIT];
    end
    else if (autoneg_failed)
    begin
      mode_next.speed_100 = autoneg_speed_100;
      mode_next.full_duplex = ctrl_reg_value[PPCD_LS_DUPLEX_BIT];
    end
    else if (autoneg_done)
    begin
      mode_next.speed_100 = autoneg_speed_100;
      mode_next.full_duplex = autoneg_full_duplex;
    end
    else
    begin
      mode_next.speed_100 = mode.speed_100;
      mode_next.full_duplex = mode.full_duplex;
    end
  end

  // Registered mode output
  always_ff @(posedge core_clk)
  begin
    if (srst)
      mode <= '{autoneg_on: 1'b1, speed_100: 1'b1, full_duplex: 1'b0};
    else
      mode <= mode_next;
  end

endmodule

`default_nettype wire

// ### hw/ppcd_top.sv
// Per-port cable diagnostic, link control and forced speed register bank
//
// How it works
// - Outcome codes: normal, open, short, failed
// - Software sets test go; hardware clears when done
// - Nine-bit read-only fault distance count, split
// - Energy saving bit enables port power saving
// - Remote loopback returns receive data to transmit
// - Bit 7 disables autoneg, forcing bits 6:5
// - Bit 6 picks 100 or 10 Mbit
// - Bit 5 picks duplex, also on autoneg failure
// - Autoneg disable ignored in reduced MII mode
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module ppcd_top
  import ppcd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Cable tester handshake
  input wire ppcd_test_result_t test_result,
  output logic cable_test_go,
  // Link detection and auto-negotiation from the transceivers
  input wire logic [1:0] link_detect,
  input wire logic [1:0] autoneg_done,
  input wire logic [1:0] autoneg_failed,
  input wire logic [1:0] autoneg_speed_100,
  input wire logic [1:0] autoneg_full_duplex,
  input wire logic fourth_port_reduced_mii_switch_mode,
  // Port controls to the transceiver
  output logic link_pass,
  output logic port_energy_saving,
  output logic remote_loopback,
  output ppcd_port_mode_t port1_mode,
  output ppcd_port_mode_t port2_mode,
  // Interrupt
  output logic irq
);

  logic [7:0] port1_link_speed_control_reg;
  logic [7:0] port2_link_speed_control_reg;
  logic cable_test_go_reg;
  ppcd_outcome_t cable_test_outcome_reg;
  logic [8:0] cable_fault_distance_count_reg;
  logic force_link_reg;
  logic energy_reg;
  logic loopback_reg;
  logic link_pass_next;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_mask_reg;
  logic [2:0] irq_events;
  logic [7:0] rdata_next;
  logic test_done;

  // True when a write strobe hits the given offset
  function automatic logic wr_hit(input logic [7:0] ofs);
    wr_hit = reg_wr && (reg_addr == ofs);
  endfunction

  // Rewrite a link speed control value, keeping reserved bits fixed
  function automatic logic [7:0] ls_write(input logic [7:0] wdata);
    ls_write = {wdata[PPCD_LS_AN_OFF_BIT:PPCD_LS_DUPLEX_BIT],
                PPCD_LS_RESET[PPCD_LS_RSVD_HI:0]};
  endfunction

  // Completion only counts while a test is running
  assign test_done = cable_test_go_reg & test_result.done;

  // Link speed control registers
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      port1_link_speed_control_reg <= PPCD_LS_RESET;
      port2_link_speed_control_reg <= PPCD_LS_RESET;
    end
    else
    begin
      if (wr_hit(PPCD_OFS_PORT1_SPEED))
        port1_link_speed_control_reg <= ls_write(reg_wdata);
      if (wr_hit(PPCD_OFS_PORT2_SPEED))
        port2_link_speed_control_reg <= ls_write(reg_wdata);
    end
  end

  // Test go bit: software sets, completion clears
  always_ff @(posedge core_clk)
  begin
    if (srst)
      cable_test_go_reg <= 1'b0;
    else if (wr_hit(PPCD_OFS_CABLE_TEST) && reg_wdata[PPCD_CT_GO_BIT])
      cable_test_go_reg <= 1'b1;
    else if (test_done)
      cable_test_go_reg <= 1'b0;
  end

  // Outcome and fault count, captured on completion and held
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cable_test_outcome_reg <= PPCD_CABLE_NORMAL;
      cable_fault_distance_count_reg <= PPCD_ZERO9;
    end
    else if (test_done)
    begin
      cable_test_outcome_reg <= test_result.outcome;
      cable_fault_distance_count_reg <= test_result.fault_count;
    end
  end

  // Port control bits
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      force_link_reg <= 1'b0;
      energy_reg <= 1'b0;
      loopback_reg <= 1'b0;
    end
    else if (wr_hit(PPCD_OFS_PORT_CTRL))
    begin
      force_link_reg <= reg_wdata[PPCD_PC_FORCE_LINK_BIT];
      energy_reg <= reg_wdata[PPCD_PC_ENERGY_BIT];
      loopback_reg <= reg_wdata[PPCD_PC_LOOPBACK_BIT];
    end
  end

  // Link reported as passing when forced
  assign link_pass_next = force_link_reg | link_detect[0];

  // Registered controls toward the transceiver
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      link_pass <= 1'b0;
      port_energy_saving <= 1'b0;
      remote_loopback <= 1'b0;
      cable_test_go <= 1'b0;
    end
    else
    begin
      link_pass <= link_pass_next;
      port_energy_saving <= energy_reg;
      remote_loopback <= loopback_reg;
      cable_test_go <= cable_test_go_reg;
    end
  end

  // Port 1 mode resolution
  ppcd_port_mode u_port1_mode (
    .core_clk(core_clk),
    .srst(srst),
    .ctrl_reg_value(port1_link_speed_control_reg),
    .reduced_mii_mode(1'b0),
    .autoneg_done(autoneg_done[0]),
    .autoneg_failed(autoneg_failed[0]),
    .autoneg_speed_100(autoneg_speed_100[0]),
    .autoneg_full_duplex(autoneg_full_duplex[0]),
    .mode(port1_mode)
  );

  // Port 2 mode resolution; this instance stands for the reduced MII port
  ppcd_port_mode u_port2_mode (
    .core_clk(core_clk),
    .srst(srst),
    .ctrl_reg_value(port2_link_speed_control_reg),
    .reduced_mii_mode(fourth_port_reduced_mii_switch_mode),
    .autoneg_done(autoneg_done[1]),
    .autoneg_failed(autoneg_failed[1]),
    .autoneg_speed_100(autoneg_speed_100[1]),
    .autoneg_full_duplex(autoneg_full_duplex[1]),
    .mode(port2_mode)
  );

  // Events: test done, link change, test reported failure
  always_comb
  begin
    irq_events = 3'h0;
    irq_events[PPCD_EV_TEST_DONE] = test_done;
    irq_events[PPCD_EV_LINK_CHANGE] = link_pass_next ^ link_pass;
    irq_events[PPCD_EV_TEST_FAULT] = test_done &
      (test_result.outcome == PPCD_CABLE_TEST_FAILED);
  end

  // Sticky status cleared by read; a new event wins over the clear
  always_ff @(posedge core_clk)
  begin
    if (srst)
      irq_status_reg <= 3'h0;
    else if (reg_rd && reg_addr == PPCD_OFS_IRQ_STATUS)
      irq_status_reg <= irq_events;
    else
      irq_status_reg <= irq_status_reg | irq_events;
  end

  // Interrupt mask
  always_ff @(posedge core_clk)
  begin
    if (srst)
      irq_mask_reg <= 3'h0;
    else if (wr_hit(PPCD_OFS_IRQ_MASK))
      irq_mask_reg <= reg_wdata[2:0];
  end

  // Level interrupt from flop
  always_ff @(posedge core_clk)
  begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= |((irq_status_reg | irq_events) & irq_mask_reg);
  end

  // Read decode
  always_comb
  begin
    rdata_next = PPCD_ZERO8;
    if (reg_addr == PPCD_OFS_CABLE_TEST)
    begin
      rdata_next[PPCD_CT_OUTCOME_HI:PPCD_CT_OUTCOME_LO] = cable_test_outcome_reg;
      rdata_next[PPCD_CT_GO_BIT] = cable_test_go_reg;
      rdata_next[PPCD_CT_FAULT_HI_BIT] = cable_fault_distance_count_reg[8];
    end
    else if (reg_addr == PPCD_OFS_FAULT_LOW)
      rdata_next = cable_fault_distance_count_reg[7:0];
    else if (reg_addr == PPCD_OFS_PORT1_SPEED)
      rdata_next = port1_link_speed_control_reg;
    else if (reg_addr == PPCD_OFS_PORT2_SPEED)
      rdata_next = port2_link_speed_control_reg;
    else if (reg_addr == PPCD_OFS_PORT_CTRL)
    begin
      rdata_next[PPCD_PC_FORCE_LINK_BIT] = force_link_reg;
      rdata_next[PPCD_PC_ENERGY_BIT] = energy_reg;
      rdata_next[PPCD_PC_LOOPBACK_BIT] = loopback_reg;
    end
    else if (reg_addr == PPCD_OFS_IRQ_STATUS)
      rdata_next[2:0] = irq_status_reg;
    else if (reg_addr == PPCD_OFS_IRQ_MASK)
      rdata_next[2:0] = irq_mask_reg;
  end

  // Read data valid the cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk)
  begin
    if (srst)
      reg_rdata <= PPCD_ZERO8;
    else if (reg_rd)
      reg_rdata <= rdata_next;
    else
      reg_rdata <= PPCD_ZERO8;
  end

endmodule

`default_nettype wire

// ### testbench/ppcd_top_asserts.sv
// Concurrent checks on the register bank ports
`timescale 1ns/1ps
`default_nettype none

module ppcd_top_asserts
  import ppcd_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Cable tester
  input wire ppcd_test_result_t test_result,
  input wire logic cable_test_go,
  // Link and mode
  input wire logic [1:0] link_detect,
  input wire logic [1:0] autoneg_done,
  input wire logic [1:0] autoneg_failed,
  input wire logic [1:0] autoneg_speed_100,
  input wire logic fourth_port_reduced_mii_switch_mode,
  input wire logic link_pass,
  input wire ppcd_port_mode_t port1_mode,
  input wire ppcd_port_mode_t port2_mode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // Start request written to the test register
  sequence s_go_write;
    reg_wr && reg_addr == PPCD_OFS_CABLE_TEST && reg_wdata[PPCD_CT_GO_BIT] && !test_result.done;
  endsequence
  // Tester reports completion while a test runs
  sequence s_test_done;
    cable_test_go && test_result.done;
  endsequence

  AST_GO_RISE: assert property (s_go_write |-> ##2 cable_test_go)
    else $error("test go output did not follow the start write");
  AST_GO_CLR: assert property (s_test_done |-> ##2 !cable_test_go)
    else $error("test go output did not clear after completion");
  AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  AST_RD_UNMAP: assert property (reg_rd && reg_addr == 8'h10 |=> reg_rdata == 8'h00)
    else $error("unmapped read returned data");
  AST_RSVD: assert property (reg_rd && (reg_addr == PPCD_OFS_PORT1_SPEED ||
    reg_addr == PPCD_OFS_PORT2_SPEED) |=> reg_rdata[4:0] == 5'h1f)
    else $error("reserved speed bits not read as ones");
  AST_LINK: assert property (link_detect[0] |=> link_pass)
    else $error("detected link not reported");
  AST_RMII: assert property (fourth_port_reduced_mii_switch_mode |=> port2_mode.autoneg_on)
    else $error("reduced mode port turned autoneg off");
  AST_SPD: assert property (port1_mode.autoneg_on && (autoneg_failed[0] || autoneg_done[0]) &&
    !$past(reg_wr) |=> port1_mode.speed_100 == $past(autoneg_speed_100[0]))
    else $error("negotiated speed not used");
endmodule

`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the cable diagnostic and link control registers
`timescale 1ns/1ps
`default_nettype none

module testbench;
  import ppcd_pkg::*;
  logic core_clk = 1'h0, srst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  ppcd_test_result_t test_result = '0;
  logic [1:0] link_detect = 2'h0, autoneg_done = 2'h0, autoneg_failed = 2'h0;
  logic [1:0] autoneg_speed_100 = 2'h0, autoneg_full_duplex = 2'h0;
  logic fourth_port_reduced_mii_switch_mode = 1'h0;
  logic cable_test_go, link_pass, port_energy_saving, remote_loopback, irq;
  ppcd_port_mode_t port1_mode, port2_mode;
  int failures = 0;
  int n_checks = 0;
  logic [8:0] cnts [4] = '{9'h000, 9'h1ff, 9'h100, 9'h0ab};

  // 25 MHz core clock
  always #20 core_clk = ~core_clk;

  // Device under test
  ppcd_top dut (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .test_result, .cable_test_go, .link_detect, .autoneg_done, .autoneg_failed,
    .autoneg_speed_100, .autoneg_full_duplex, .fourth_port_reduced_mii_switch_mode,
    .link_pass, .port_energy_saving, .remote_loopback, .port1_mode, .port2_mode, .irq);

  // Compare a seen value with the expected one
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // Let registered outputs land past some edges
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // One-cycle register write
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  // One-cycle read, data compared in the cycle after
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    #1;
    check(reg_rdata, e);
  endtask
  // Start a cable test and let the tester finish it
  task automatic cable(input logic [1:0] oc, input logic [8:0] cnt);
    wr(PPCD_OFS_CABLE_TEST, 8'h10);
    settle(1);
    check(cable_test_go, 1'h1);
    @(posedge core_clk);
    test_result <= {1'h1, oc, cnt};
    @(posedge core_clk);
    test_result <= {1'h0, ~oc, ~cnt};
    settle(2);
    check(cable_test_go, 1'h0);
    rd(PPCD_OFS_CABLE_TEST, {1'h0, oc, 4'h0, cnt[8]});
    rd(PPCD_OFS_FAULT_LOW, cnt[7:0]);
  endtask
  // Verdict and end of run
  task automatic test_done();
    if (failures == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge core_clk);
    failures++;
    test_done();
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge core_clk);
    srst <= 1'h0;
    settle(1);
    check({port1_mode, port2_mode}, 6'h36);
    check({cable_test_go, link_pass, port_energy_saving, remote_loopback, irq}, 5'h00);
    rd(PPCD_OFS_PORT2_SPEED, 8'h5f);
    rd(PPCD_OFS_PORT_CTRL, 8'h00);
    rd(PPCD_OFS_IRQ_MASK, 8'h00);
    // Unmapped and read-only places ignore writes
    wr(8'h10, 8'hff);
    wr(PPCD_OFS_FAULT_LOW, 8'hff);
    wr(PPCD_OFS_CABLE_TEST, 8'h61);
    rd(8'h10, 8'h00);
    rd(PPCD_OFS_FAULT_LOW, 8'h00);
    rd(PPCD_OFS_CABLE_TEST, 8'h00);
    // Port controls and masked link change events
    wr(PPCD_OFS_PORT_CTRL, 8'h07);
    settle(1);
    check({link_pass, port_energy_saving, remote_loopback}, 3'h7);
    rd(PPCD_OFS_PORT_CTRL, 8'h07);
    wr(PPCD_OFS_PORT_CTRL, 8'h01);
    link_detect <= 2'h1;
    settle(2);
    check({link_pass, port_energy_saving, remote_loopback}, 3'h5);
    @(posedge core_clk);
    link_detect <= 2'h0;
    settle(2);
    check({link_pass, irq}, 2'h0);
    rd(PPCD_OFS_IRQ_STATUS, 8'h02);
    rd(PPCD_OFS_IRQ_STATUS, 8'h00);
    // Forced and negotiated speed and duplex
    wr(PPCD_OFS_PORT1_SPEED, 8'h80);
    settle(1);
    check(port1_mode, 3'h0);
    rd(PPCD_OFS_PORT1_SPEED, 8'h9f);
    wr(PPCD_OFS_PORT1_SPEED, 8'he0);
    settle(1);
    check(port1_mode, 3'h3);
    wr(PPCD_OFS_PORT1_SPEED, 8'h20);
    autoneg_failed <= 2'h1;
    autoneg_speed_100 <= 2'h1;
    settle(2);
    check(port1_mode, 3'h7);
    @(posedge core_clk);
    autoneg_failed <= 2'h0;
    autoneg_done <= 2'h3;
    autoneg_speed_100 <= 2'h0;
    autoneg_full_duplex <= 2'h1;
    fourth_port_reduced_mii_switch_mode <= 1'h1;
    settle(2);
    check(port1_mode, 3'h5);
    wr(PPCD_OFS_PORT2_SPEED, 8'h40);
    settle(1);
    check(port2_mode, 3'h6);
    wr(PPCD_OFS_PORT2_SPEED, 8'ha0);
    settle(1);
    check(port2_mode, 3'h5);
    // Every outcome code with an unmasked completion interrupt
    wr(PPCD_OFS_IRQ_MASK, 8'h05);
    for (int i = 0; i < 4; i++)
    begin
      cable(i[1:0], cnts[i]);
      check(irq, 1'h1);
      rd(PPCD_OFS_IRQ_STATUS, {5'h0, i == 3, 2'h1});
      settle(1);
      check(irq, 1'h0);
    end
    // A completion report with no test running changes nothing
    @(posedge core_clk);
    test_result <= {1'h1, 2'h1, 9'h055};
    @(posedge core_clk);
    test_result <= '0;
    rd(PPCD_OFS_CABLE_TEST, 8'h60);
    rd(PPCD_OFS_FAULT_LOW, 8'hab);
    rd(PPCD_OFS_IRQ_STATUS, 8'h00);
    test_done();
  end
endmodule

bind ppcd_top ppcd_top_asserts u_chk (.core_clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .test_result, .cable_test_go, .link_detect, .autoneg_done,
  .autoneg_failed, .autoneg_speed_100, .fourth_port_reduced_mii_switch_mode, .link_pass,
  .port1_mode, .port2_mode);

`default_nettype wire
